/* pkg/line_clock_pkg.sv */
// constants and carrier types for the line clock bus interface
package line_clock_pkg;
  localparam int ADDR_W  = 10;     // bus device address width
  localparam int BYTE_W  = 8;      // one data byte
  localparam int DATA_W  = 16;     // data lines 0..15, line 0 is msb
  localparam int ADDR_LO = 6;      // address sits on lines 6..15
  localparam int BYTE_LO = 8;      // bytes sit on lines 8..15
  // command byte fields, positions within the byte (line 8 = bit 7)
  localparam int CMD_ENABLE  = 7;  // line 8: enable interrupt
  localparam int CMD_DISABLE = 6;  // line 9: disable interrupt
  localparam int CMD_ARM     = 5;  // line 10: arm
  localparam int CMD_DISARM  = 4;  // line 11: disarm
  // status byte fields
  localparam int ST_OVERRUN = 7;   // interval overrun
  localparam int ST_QUEUED  = 6;   // attention queued
  localparam int ST_ENABLED = 5;   // interrupt enabled
  localparam int ST_ARMED   = 4;   // unit armed
  localparam logic [BYTE_W-1:0] STATUS_RST = 8'h00; // idle status

  // unit selected by the last address strobe
  typedef enum logic [1:0] {SEL_NONE, SEL_INTERVAL, SEL_LINE} unit_sel_t;

  // control strobes from the processor, all active high levels
  typedef struct packed {
    logic address_strobe;
    logic command_strobe;
    logic write_byte_strobe;
    logic read_byte_strobe;
    logic status_request_strobe;
    logic acknowledge_in;
  } bus_ctrl_t;

  // bus answer back to the processor
  typedef struct packed {
    logic [DATA_W-1:0] data;       // data lines, bit 15 = line 0
    logic              data_oe;    // high while driving data lines
    logic              sync_reply;
    logic              attention_request;
    logic              attention_address_strobe;
    logic              acknowledge_out;
  } bus_reply_t;
endpackage : line_clock_pkg

/* verilog/line_clock_bus_interface.sv */
// bus port, address decode and line unit of the two-unit clock module
// What this block does
// [R1] line pulse is the line unit's only time source
// [R2] system clear disarms and disables line unit
// [R3] line unit acts on enable/disable commands only
// [R4] armed line pulse sets line attention queue
// [R5] line queue requests attention only when enabled
// [R6] disarmed line unit holds its queue cleared
// [R7] even address interval, odd address line unit
// [R8] strobes go only to last selected unit
// [R9] base address set by ten-bit switches
// [R10] interval unit wins acknowledge over line unit
// [R11] address strobe latches address, answers sync
// [R12] command strobe accepted by selected unit, sync
// [R13] write strobe takes low byte, answers sync
// [R14] read strobe drives data byte then sync
// [R15] status strobe drives status byte then sync
// [R16] acknowledge returns address with attention strobe
// [R17] sync answers strobe, drops when strobe drops
// [R18] attention held until acknowledge arrives
// [R19] data byte toggle flips on gated read/write
// [R20] write byte toggle flips on gated write
// [R21] expiry during half transfer sets overrun
// [R22] writes load low/high, reads return low/high
// [R23] overrun held until status, acknowledge, clear
// [R24] idle device passes acknowledge downstream
// [R25] command byte bit encoding is our choice
module line_clock_bus_interface
  import line_clock_pkg::*;
(
  input  wire logic              clk_i,                   // 100 MHz
  input  wire logic              sys_rst_i,               // system clear
  input  wire bus_ctrl_t         bus_ctrl_i,              // strobes
  input  wire logic [DATA_W-1:0] bus_data_i,              // data lines in
  input  wire logic [ADDR_W-1:0] base_address_i,          // switches
  input  wire logic              line_pulse_i,            // mains pulse
  input  wire logic              interval_expiry_pulse_i, // timer expiry
  input  wire logic [DATA_W-1:0] interval_count_i,        // output buffer
  output bus_reply_t             bus_reply_o,             // bus answer
  output logic                   load_low_byte_o,         // pulse
  output logic                   load_high_byte_o,        // pulse
  output logic [BYTE_W-1:0]      interval_write_data_o,   // byte taken
  output logic                   overrun_flag_o           // level
);

  // strobe history for edge detection
  bus_ctrl_t ctrl_prev_q;
  // rising edges of each strobe
  logic addr_rise, cmd_rise, wr_rise, rd_rise, sr_rise, ack_rise;
  // any control line apart from acknowledge
  logic any_ctrl;
  // byte on lines 8..15 and address on lines 6..15
  logic [BYTE_W-1:0] in_byte;
  logic [ADDR_W-1:0] in_addr;

  unit_sel_t sel_q;                   // last selected unit
  logic      line_interrupt_enable_q; // line unit enable
  logic      line_armed_q;            // low = line_disarm active
  logic      line_attention_queue_q;  // queued line request
  logic      interval_interrupt_enable_q;
  logic      interval_armed_q;
  logic      interval_attention_queue_q;
  logic      data_byte_toggle_q;      // low or high byte next
  logic      write_byte_toggle_q;     // two-byte write half done
  logic      overrun_q;
  logic      gated_write_strobe;      // write to interval unit
  logic      gated_read_strobe;       // read from interval unit
  logic      gated_status;            // status to interval unit
  logic      line_pending, interval_pending;
  logic      ack_taken;               // acknowledge absorbed here
  logic      serve_interval;          // acknowledge answered by interval
  logic      act_q;                   // strobe accepted last cycle
  logic      answering;               // a selected unit answers
  logic      reply_oe_q;                 // driving the data lines
  logic      sync_reply_q;               // bus sync answer
  logic      attention_request_q;        // shared attention line
  logic      attention_address_strobe_q; // address return strobe
  logic      acknowledge_out_q;          // downstream acknowledge
  logic [DATA_W-1:0] reply_data_q;       // driven data lines

  // edge detect on all strobes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_prev_q <= '0;
    end else begin
      ctrl_prev_q <= bus_ctrl_i;
    end
  end

  assign addr_rise = bus_ctrl_i.address_strobe & ~ctrl_prev_q.address_strobe;
  assign cmd_rise  = bus_ctrl_i.command_strobe & ~ctrl_prev_q.command_strobe;
  assign wr_rise   = bus_ctrl_i.write_byte_strobe & ~ctrl_prev_q.write_byte_strobe;
  assign rd_rise   = bus_ctrl_i.read_byte_strobe & ~ctrl_prev_q.read_byte_strobe;
  assign sr_rise   = bus_ctrl_i.status_request_strobe
                   & ~ctrl_prev_q.status_request_strobe;
  assign ack_rise  = bus_ctrl_i.acknowledge_in & ~ctrl_prev_q.acknowledge_in;
  assign any_ctrl  = bus_ctrl_i.address_strobe | bus_ctrl_i.command_strobe
                   | bus_ctrl_i.write_byte_strobe | bus_ctrl_i.read_byte_strobe
                   | bus_ctrl_i.status_request_strobe;
  assign in_byte   = bus_data_i[BYTE_W-1:0];
  assign in_addr   = bus_data_i[ADDR_W-1:0];

  // address latch and unit select
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sel_q <= SEL_NONE;
    end else if (addr_rise) begin
      // upper nine bits match, lowest picks the unit
      if (in_addr[ADDR_W-1:1] != base_address_i[ADDR_W-1:1]) begin // R9
        sel_q <= SEL_NONE;
      end else if (in_addr[0]) begin // R7
        sel_q <= SEL_LINE;
      end else begin
        sel_q <= SEL_INTERVAL;
      end
    end
  end

  // strobes gated by the selected unit
  assign gated_write_strobe = wr_rise & (sel_q == SEL_INTERVAL); // R8
  assign gated_read_strobe  = rd_rise & (sel_q == SEL_INTERVAL); // R8
  assign gated_status       = sr_rise & (sel_q == SEL_INTERVAL); // R8

  // acknowledge handling
  assign line_pending     = line_attention_queue_q & line_interrupt_enable_q;
  assign interval_pending = interval_attention_queue_q & interval_interrupt_enable_q;
  assign ack_taken        = ack_rise & attention_request_q;
  assign serve_interval   = interval_pending; // R10

  // line unit enable and arm state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      line_interrupt_enable_q <= 1'b0; // R2
      line_armed_q            <= 1'b0; // R2
    end else if (cmd_rise && sel_q == SEL_LINE) begin
      // only enable and disable act; enable also arms, disable leaves arm set
      if (in_byte[CMD_ENABLE]) begin // R3 R25
        line_interrupt_enable_q <= 1'b1;
        line_armed_q            <= 1'b1;
      end else if (in_byte[CMD_DISABLE]) begin // R3
        line_interrupt_enable_q <= 1'b0;
      end
    end
  end

  // line attention queue
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      line_attention_queue_q <= 1'b0;
    end else if (!line_armed_q) begin
      line_attention_queue_q <= 1'b0; // R6
    end else if (line_pulse_i) begin
      line_attention_queue_q <= 1'b1; // R1 R4
    end else if (ack_taken && !serve_interval) begin
      line_attention_queue_q <= 1'b0;
    end
  end

  // interval unit enable and arm state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      interval_interrupt_enable_q <= 1'b0;
      interval_armed_q            <= 1'b0;
    end else if (cmd_rise && sel_q == SEL_INTERVAL) begin
      // same encoding as the line unit
      if (in_byte[CMD_ENABLE]) begin // R25
        interval_interrupt_enable_q <= 1'b1;
      end else if (in_byte[CMD_DISABLE]) begin
        interval_interrupt_enable_q <= 1'b0;
      end
      if (in_byte[CMD_ARM]) begin
        interval_armed_q <= 1'b1;
      end else if (in_byte[CMD_DISARM]) begin
        interval_armed_q <= 1'b0;
      end
    end
  end

  // interval attention queue, set beats acknowledge clear, disarm beats set
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      interval_attention_queue_q <= 1'b0;
    end else if (!interval_armed_q) begin
      interval_attention_queue_q <= 1'b0;
    end else if (interval_expiry_pulse_i) begin
      interval_attention_queue_q <= 1'b1;
    end else if (ack_taken && serve_interval) begin
      interval_attention_queue_q <= 1'b0; // R10
    end
  end

  // interval byte toggles
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      data_byte_toggle_q  <= 1'b0;
      write_byte_toggle_q <= 1'b0;
    end else begin
      if (gated_write_strobe || gated_read_strobe) begin
        data_byte_toggle_q <= ~data_byte_toggle_q; // R19
      end
      if (gated_write_strobe) begin
        write_byte_toggle_q <= ~write_byte_toggle_q; // R20
      end
    end
  end

  // overrun flag, set wins over clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      overrun_q <= 1'b0; // R23
    end else if (interval_expiry_pulse_i && data_byte_toggle_q) begin
      overrun_q <= 1'b1; // R21
    end else if (gated_status || ack_taken) begin
      overrun_q <= 1'b0; // R23
    end
  end

  // input buffer loads, low byte then high byte
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      load_low_byte_o       <= 1'b0;
      load_high_byte_o      <= 1'b0;
      interval_write_data_o <= '0;
    end else begin
      load_low_byte_o  <= gated_write_strobe & ~data_byte_toggle_q; // R22
      load_high_byte_o <= gated_write_strobe & data_byte_toggle_q;  // R22
      if (gated_write_strobe) begin
        interval_write_data_o <= in_byte; // R13
      end
    end
  end

  assign overrun_flag_o = overrun_q;

  // a selected unit answers this strobe
  assign answering = (addr_rise && in_addr[ADDR_W-1:1] == base_address_i[ADDR_W-1:1])
                   || (sel_q != SEL_NONE && (cmd_rise || wr_rise || rd_rise || sr_rise));

  // data lines: read byte, status byte or returned address
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reply_data_q <= '0;
      reply_oe_q   <= 1'b0;
    end else if (gated_read_strobe) begin
      reply_data_q <= {8'h00, data_byte_toggle_q ? // R14 R22
                       interval_count_i[DATA_W-1:BYTE_W] :
                       interval_count_i[BYTE_W-1:0]};
      reply_oe_q   <= 1'b1;
    end else if (sr_rise && sel_q != SEL_NONE) begin
      reply_data_q <= {8'h00,
        (sel_q == SEL_INTERVAL) ? overrun_q : 1'b0,
        (sel_q == SEL_INTERVAL) ? interval_attention_queue_q
                                : line_attention_queue_q,
        (sel_q == SEL_INTERVAL) ? interval_interrupt_enable_q
                                : line_interrupt_enable_q,
        (sel_q == SEL_INTERVAL) ? interval_armed_q : line_armed_q,
        STATUS_RST[3:0]}; // R15
      reply_oe_q   <= 1'b1;
    end else if (ack_taken) begin
      reply_data_q <= {6'h00, base_address_i[ADDR_W-1:1],
                       ~serve_interval}; // R16 R10
      reply_oe_q   <= 1'b1;
    end else if (!any_ctrl && !bus_ctrl_i.acknowledge_in) begin
      reply_oe_q   <= 1'b0;
      reply_data_q <= '0;
    end
  end

  // sync follows the accepting cycle, drops with the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      act_q        <= 1'b0;
      sync_reply_q <= 1'b0;
    end else begin
      act_q        <= answering;
      sync_reply_q <= any_ctrl & (act_q | sync_reply_q); // R11 R12 R17
    end
  end

  // attention request, held until acknowledge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      attention_request_q <= 1'b0;
    end else if (ack_taken) begin
      attention_request_q <= 1'b0; // R18
    end else begin
      attention_request_q <= line_pending | interval_pending // R5
                           | attention_request_q;            // R18
    end
  end

  // attention address strobe and acknowledge chain
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      attention_address_strobe_q <= 1'b0;
      acknowledge_out_q          <= 1'b0;
    end else begin
      // strobe once data is out, hold while acknowledge stays
      attention_address_strobe_q <= bus_ctrl_i.acknowledge_in
        & (reply_oe_q & ~ack_rise & ~acknowledge_out_q
           & (ctrl_prev_q.acknowledge_in)); // R16
      if (ack_rise) begin
        acknowledge_out_q <= ~attention_request_q; // R24
      end else begin
        acknowledge_out_q <= bus_ctrl_i.acknowledge_in & acknowledge_out_q;
      end
    end
  end

  assign bus_reply_o = {reply_data_q, reply_oe_q, sync_reply_q, // every field driven straight from flops
                        attention_request_q, attention_address_strobe_q,
                        acknowledge_out_q};

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_line_pulse_armed;
    line_pulse_i && line_armed_q;
  endsequence

  AST_LINE_PULSE_QUEUES: // R4
    assert property (s_line_pulse_armed |=> line_attention_queue_q)
      else $error("armed line pulse did not queue");
  AST_DISARM_HOLDS_CLEAR: // R6
    assert property (!line_armed_q |=> !line_attention_queue_q)
      else $error("line queue set while disarmed");
  AST_SYNC_DROPS: // R17
    assert property (!any_ctrl |=> !bus_reply_o.sync_reply)
      else $error("sync held after strobe removed");
  AST_ADDR_SYNC: // R11
    assert property ((addr_rise && in_addr == base_address_i) ##1 any_ctrl
                     |=> bus_reply_o.sync_reply)
      else $error("no sync for own address");
  AST_LINE_SELECT: // R7
    assert property ((addr_rise && in_addr[ADDR_W-1:1] == base_address_i[ADDR_W-1:1]
                      && in_addr[0])
                     |=> sel_q == SEL_LINE)
      else $error("odd address did not pick line unit");
  AST_OVERRUN_SET: // R21
    assert property ((interval_expiry_pulse_i && data_byte_toggle_q)
                     |=> overrun_q)
      else $error("overrun not set");
  AST_OVERRUN_HOLD: // R23
    assert property ((overrun_q && !gated_status && !ack_taken) |=> overrun_q)
      else $error("overrun cleared early");
  AST_WBC_ONLY_WRITE: // R20
    assert property (!gated_write_strobe |=> $stable(write_byte_toggle_q))
      else $error("write toggle moved without write");
  AST_DBC_FLIPS: // R19
    assert property ((gated_read_strobe || gated_write_strobe)
                     |=> data_byte_toggle_q != $past(data_byte_toggle_q))
      else $error("data toggle did not flip");
  AST_ATN_HOLD: // R18
    assert property ((bus_reply_o.attention_request && !ack_taken)
                     |=> bus_reply_o.attention_request)
      else $error("attention dropped before acknowledge");
  AST_ACK_PASS: // R24
    assert property ((ack_rise && !bus_reply_o.attention_request)
                     |=> bus_reply_o.acknowledge_out)
      else $error("idle device did not pass acknowledge");
  AST_PRIORITY: // R10
    assert property ((ack_taken && interval_pending)
                     |=> !bus_reply_o.data[0] && bus_reply_o.data_oe)
      else $error("interval unit lost priority");

endmodule : line_clock_bus_interface

/* sim/bus_host_model.sv */
// host processor model driving the strobe bus of the clock module
module bus_host_model
  import line_clock_pkg::*;
(
  input  wire logic         clk_i,   // bus clock
  input  wire bus_reply_t   reply_i, // device answer
  output bus_ctrl_t         ctrl_o,  // control strobes
  output logic [DATA_W-1:0] data_o   // data lines to the device
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idle at time zero
  initial begin
    ctrl_o = '0;
    data_o = 16'h0000;
  end

  // one strobe: raise, await answer, drop, await release
  task automatic xfer(input int k, input logic [DATA_W-1:0] d, output logic ok,
                      output logic [DATA_W-1:0] rd, output logic gone);
    int n;
    ok = 1'b0;
    rd = 16'hdead; // nothing driven
    @(negedge clk_i);
    data_o = d;
    ctrl_o = bus_ctrl_t'(6'h01 << k);
    for (n = 0; n < 8 && !ok; n++) begin
      @(negedge clk_i);
      ok = (reply_i.sync_reply | reply_i.attention_address_strobe |
            reply_i.acknowledge_out) === 1'b1;
    end
    if (reply_i.data_oe === 1'b1) begin
      rd = reply_i.data; // taken with the answer
    end
    ctrl_o = '0;
    data_o = ~d; // released lines show no stale value
    repeat (2) @(negedge clk_i);
    gone = (reply_i.sync_reply | reply_i.attention_address_strobe) === 1'b0;
  endtask : xfer
endmodule : bus_host_model

/* sim/testbench.sv */
// self-checking bench for the line clock bus interface
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import line_clock_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 10'h2a6; // interval even, line odd
  localparam int AS = 5; // address strobe
  localparam int CM = 4; // command strobe
  localparam int WR = 3; // write strobe
  localparam int RD = 2; // read strobe
  localparam int SR = 1; // status strobe
  localparam int AK = 0; // acknowledge
  logic              clk_i;
  logic              sys_rst_i;
  logic              line_pulse_i;
  logic              expiry_i;
  logic [DATA_W-1:0] data_i;
  bus_ctrl_t         ctrl;
  bus_reply_t        reply;
  logic              lo;
  logic              hi;
  logic [BYTE_W-1:0] wdata;
  logic              ovr;
  logic              ok;
  logic              gone;
  logic [DATA_W-1:0] rd;
  int                miscompares;
  int                comparisons;
  int                lo_n;
  int                hi_n;

  bus_host_model host_u (.clk_i(clk_i), .reply_i(reply), .ctrl_o(ctrl), .data_o(data_i));

  line_clock_bus_interface dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_ctrl_i(ctrl), .bus_data_i(data_i),
    .base_address_i(BASE), .line_pulse_i(line_pulse_i),
    .interval_expiry_pulse_i(expiry_i), .interval_count_i(16'hbeef),
    .bus_reply_o(reply), .load_low_byte_o(lo), .load_high_byte_o(hi),
    .interval_write_data_o(wdata), .overrun_flag_o(ovr));

  // clock generation
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // count load pulses
  always @(posedge clk_i) begin
    if (lo === 1'b1) lo_n++;
    if (hi === 1'b1) hi_n++;
  end

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic op(input int k, input logic [DATA_W-1:0] d);
    host_u.xfer(k, d, ok, rd, gone);
  endtask : op

  // one-cycle pulse on mains or expiry input, then settle
  task automatic tick(input logic mains);
    @(negedge clk_i);
    if (mains) line_pulse_i = 1'b1;
    else expiry_i = 1'b1;
    @(negedge clk_i);
    line_pulse_i = 1'b0;
    expiry_i = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : tick

  task automatic t_decode;
    chk(16'(reply), 16'h0000);
    op(WR, 16'h0055);
    chk(16'(ok), 16'h0000);
    op(AS, 16'h0155);
    chk(16'(ok), 16'h0000);
    op(AS, 16'(BASE));
    chk(16'(ok), 16'h0001);
    chk(16'(gone), 16'h0001);
  endtask : t_decode

  task automatic t_interval;
    op(WR, 16'h0034);
    chk(16'({lo_n[3:0], hi_n[3:0], wdata}), 16'h1034);
    op(WR, 16'h0012);
    chk(16'({lo_n[3:0], hi_n[3:0], wdata}), 16'h1112);
    op(RD, 16'h0000);
    chk(rd, 16'h00ef);
    op(RD, 16'h0000);
    chk(rd, 16'h00be);
    chk(16'(gone), 16'h0001);
  endtask : t_interval

  task automatic t_overrun;
    op(WR, 16'h0001);
    tick(1'b0);
    chk(16'(ovr), 16'h0001);
    op(WR, 16'h0002);
    chk(16'(ovr), 16'h0001);
    op(SR, 16'h0000);
    chk(16'(rd[7]), 16'h0001);
    chk(16'(ovr), 16'h0000);
    tick(1'b0);
    chk(16'(ovr), 16'h0000);
  endtask : t_overrun

  task automatic t_line;
    op(AS, 16'(BASE) | 16'h0001);
    chk(16'(ok), 16'h0001);
    op(SR, 16'h0000);
    chk(rd, 16'h0000);
    tick(1'b1);
    chk(16'(reply.attention_request), 16'h0000);
    op(SR, 16'h0000);
    chk(rd, 16'h0000);
    op(CM, 16'h0080);
    tick(1'b1);
    chk(16'(reply.attention_request), 16'h0001);
    op(SR, 16'h0000);
    chk(rd, 16'h0070);
    chk(16'(reply.attention_request), 16'h0001);
    op(AK, 16'h0000);
    chk(rd, 16'(BASE) | 16'h0001);
    chk(16'(reply.attention_request), 16'h0000);
    op(AK, 16'h0000);
    chk({rd[15:1], ok}, 16'hdead);
    op(CM, 16'h0040);
    tick(1'b1);
    chk(16'(reply.attention_request), 16'h0000);
    op(SR, 16'h0000);
    chk(rd, 16'h0050);
    op(WR, 16'h0077);
    chk({rd[7:1], ok, wdata}, 16'had02);
    op(RD, 16'h0000);
    chk({rd[15:1], ok}, 16'hdead);
    op(CM, 16'h0010);
    op(SR, 16'h0000);
    chk(rd, 16'h0050);
  endtask : t_line

  task automatic t_priority;
    op(CM, 16'h0080);
    tick(1'b1);
    op(AS, 16'(BASE));
    op(CM, 16'h00a0);
    tick(1'b0);
    op(AK, 16'h0000);
    chk(rd, 16'(BASE));
    op(AK, 16'h0000);
    chk(rd, 16'(BASE) | 16'h0001);
    op(AS, 16'(BASE) | 16'h0001);
    op(CM, 16'h0080);
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    tick(1'b1);
    chk(16'(reply.attention_request), 16'h0000);
  endtask : t_priority

  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    miscompares = 0;
    comparisons = 0;
    lo_n = 0;
    hi_n = 0;
    sys_rst_i = 1'b1;
    line_pulse_i = 1'b0;
    expiry_i = 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_decode();
    t_interval();
    t_overrun();
    t_line();
    t_priority();
    tally_and_finish();
  end
endmodule : testbench
